// *** design/timer16_pkg.sv ***
// register map, field layout and reset values of the 16-bit timer unit
package timer16_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] run_control_ofs = 8'h00;
  localparam logic [7:0] mode_ofs = 8'h04;
  localparam logic [7:0] ff_control_ofs = 8'h08;
  localparam logic [7:0] duty_ofs = 8'h0c;
  localparam logic [7:0] period_ofs = 8'h10;
  localparam logic [7:0] capture_ofs = 8'h14;
  localparam logic [7:0] counter_ofs = 8'h18;
  localparam logic [7:0] int_status_ofs = 8'h1c;
  localparam logic [7:0] int_clear_ofs = 8'h20;
  localparam logic [7:0] int_enable_ofs = 8'h24;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int run_bit_pos = 0;
  localparam int prescaler_run_pos = 2;
  localparam int double_buffer_pos = 7;
  localparam int clk_src_lsb = 0;
  localparam int clear_on_period_pos = 2;
  localparam int soft_capture_pos = 3;
  localparam int ff_code_lsb = 0;
  localparam int ff_duty_trig_pos = 2;
  localparam int ff_period_trig_pos = 3;
  localparam int ff_state_pos = 4;
  localparam int duty_irq_bit = 0;
  localparam int period_irq_bit = 1;
  localparam int duty_level_lsb = 0;
  localparam int duty_enable_pos = 3;
  localparam int period_level_lsb = 4;
  localparam int period_enable_pos = 7;

  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] src_external = 2'h0;
  localparam logic [1:0] src_presc_a = 2'h1;
  localparam logic [1:0] src_presc_b = 2'h2;
  localparam logic [1:0] src_presc_c = 2'h3;
  localparam logic [7:0] presc_mask_a = 8'h03;
  localparam logic [7:0] presc_mask_b = 8'h0f;
  localparam logic [7:0] presc_mask_c = 8'h3f;
  localparam logic [1:0] ff_code_invert = 2'h0;
  localparam logic [1:0] ff_code_set = 2'h1;
  localparam logic [1:0] ff_code_clear = 2'h2;
  localparam logic [7:0] run_control_rst = 8'h00;
  localparam logic [3:0] mode_rst = 4'h1;
  localparam logic [3:0] ff_control_rst = 4'h3;
  localparam logic [15:0] compare_rst = 16'hffff;
  localparam logic [7:0] int_enable_rst = 8'h00;
  localparam logic [1:0] no_ff_write = 2'h3;

endpackage : timer16_pkg

// *** design/pin_rise_detect.sv ***
// two-flop synchroniser for a pin, with a one-cycle rising-edge pulse
`timescale 1ns/100ps
module pin_rise_detect (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic pin, // asynchronous pin level
  output logic rise // one-cycle pulse per rising edge
);

  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // only the second flop and its delayed copy feed the edge logic
  assign rise = sync_q & ~last_q;

endmodule : pin_rise_detect

// *** design/timer16_unit.sv ***
// 16-bit interval timer, event counter and pulse generator with an APB slave
// Overview of operation
// - period match raises periodic period interrupt
// - external source counts each pin rising edge while the prescaler run bit is set
// - duty or period match inverts output flop
// - buffered duty loads only on period match
// - any frequency, duty; polarity by initial flop
// - codes 01,10,11 prescaler taps, else pin
// - per-interrupt enable and programmable priority level
// - run bit zero stops and clears counter
// - two comparators raise their compare interrupts
// - flop code 00 invert, 01 set, 10 clear
`timescale 1ns/100ps
module timer16_unit
  import timer16_pkg::*;
(
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic event_input_pin, // external count input
  output logic pulse_output_pin, // output toggle flip-flop level
  output logic irq, // level interrupt
  output logic [2:0] irq_level // priority of the highest pending interrupt
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr;
  logic setup;
  logic ext_rise;
  logic [31:0] rd_mux;
  logic rd_err;
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign pready = penable;
  pin_rise_detect event_sync (
    .clk(pclk),
    .rst_n(presetn),
    .pin(event_input_pin),
    .rise(ext_rise)
  );

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic run_q, run_d;
  logic prun_q, prun_d;
  logic dbe_q, dbe_d;
  logic [3:0] mode_q, mode_d;
  logic [3:0] ffc_q, ffc_d;
  logic [15:0] duty_q, duty_d;
  logic [15:0] duty_buf_q, duty_buf_d;
  logic [15:0] period_q, period_d;
  logic [15:0] capture_q, capture_d;
  logic [7:0] int_en_q, int_en_d;
  logic [1:0] ff_wr;
  logic [1:0] clk_src;
  logic [7:0] presc_q, presc_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cnt_inc;
  logic [7:0] presc_mask;
  logic tick;
  logic hit_duty;
  logic hit_period;
  logic wrap;

  assign clk_src = mode_q[clk_src_lsb +: 2];
  always_comb begin
    run_d = run_q;
    prun_d = prun_q;
    dbe_d = dbe_q;
    mode_d = mode_q;
    ffc_d = ffc_q;
    duty_d = duty_q;
    duty_buf_d = duty_buf_q;
    period_d = period_q;
    capture_d = capture_q;
    int_en_d = int_en_q;
    ff_wr = no_ff_write;
    if (wr && paddr == run_control_ofs) begin
      run_d = pwdata[run_bit_pos];
      prun_d = pwdata[prescaler_run_pos];
      dbe_d = pwdata[double_buffer_pos];
    end else if (wr && paddr == mode_ofs) begin
      mode_d = {1'b0, pwdata[2:0]};
    end else if (wr && paddr == ff_control_ofs) begin
      ffc_d = {pwdata[3:2], no_ff_write};
      ff_wr = pwdata[ff_code_lsb +: 2];
    end else if (wr && paddr == duty_ofs) begin
      // with the buffer on, the live compare value changes only at a period match
      duty_buf_d = pwdata[15:0];
      if (!dbe_q) begin
        duty_d = pwdata[15:0];
      end
    end else if (wr && paddr == period_ofs) begin
      period_d = pwdata[15:0];
    end else if (wr && paddr == int_enable_ofs) begin
      int_en_d = pwdata[7:0];
    end
    // capture is a write-one strobe; the bit does not stay set
    if (wr && paddr == mode_ofs && pwdata[soft_capture_pos]) begin
      capture_d = cnt_q;
    end
    if (dbe_q && hit_period) begin
      duty_d = duty_buf_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= run_control_rst[run_bit_pos];
      prun_q <= run_control_rst[prescaler_run_pos];
      dbe_q <= run_control_rst[double_buffer_pos];
      mode_q <= mode_rst;
      ffc_q <= ff_control_rst;
      duty_q <= compare_rst;
      duty_buf_q <= compare_rst;
      period_q <= compare_rst;
      capture_q <= 16'h0000;
      int_en_q <= int_enable_rst;
    end else begin
      run_q <= run_d;
      prun_q <= prun_d;
      dbe_q <= dbe_d;
      mode_q <= mode_d;
      ffc_q <= ffc_d;
      duty_q <= duty_d;
      duty_buf_q <= duty_buf_d;
      period_q <= period_d;
      capture_q <= capture_d;
      int_en_q <= int_en_d;
    end
  end

  // ---------------------------------------------------------------
  // prescaler, counter and comparators
  // ---------------------------------------------------------------
  assign presc_mask = (clk_src == src_presc_a) ? presc_mask_a :
                      (clk_src == src_presc_b) ? presc_mask_b : presc_mask_c;
  assign cnt_inc = cnt_q + 16'h0001;
  // the pin source is also gated by the prescaler run bit
  assign tick = prun_q & ((clk_src == src_external) ? ext_rise :
                &(presc_q | ~presc_mask));
  assign hit_duty = run_q & tick & (cnt_inc == duty_q);
  assign hit_period = run_q & tick & (cnt_inc == period_q);
  assign wrap = mode_q[clear_on_period_pos] & (cnt_q == period_q);

  always_comb begin
    presc_d = prun_q ? presc_q + 8'h01 : 8'h00;
    cnt_d = cnt_q;
    if (!run_q) begin
      cnt_d = 16'h0000;
    end else if (tick && wrap) begin
      cnt_d = 16'h0000;
    end else if (tick) begin
      cnt_d = cnt_inc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 8'h00;
      cnt_q <= 16'h0000;
    end else begin
      presc_q <= presc_d;
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // output toggle flip-flop
  // ---------------------------------------------------------------
  logic ff_q, ff_d;
  always_comb begin
    ff_d = ff_q;
    // a software code in the same cycle as a match takes precedence
    if (ff_wr == ff_code_invert) begin
      ff_d = ~ff_q;
    end else if (ff_wr == ff_code_set) begin
      ff_d = 1'b1;
    end else if (ff_wr == ff_code_clear) begin
      ff_d = 1'b0;
    end else if ((hit_duty && ffc_q[ff_duty_trig_pos])
                 || (hit_period && ffc_q[ff_period_trig_pos])) begin
      ff_d = ~ff_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_q <= 1'b0;
    end else begin
      ff_q <= ff_d;
    end
  end

  assign pulse_output_pin = ff_q;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [1:0] status_q, status_d;
  logic [1:0] live;
  logic [2:0] lvl_duty;
  logic [2:0] lvl_period;

  assign lvl_duty = int_en_q[duty_level_lsb +: 3];
  assign lvl_period = int_en_q[period_level_lsb +: 3];
  assign live = status_q & {int_en_q[period_enable_pos], int_en_q[duty_enable_pos]};

  always_comb begin
    status_d = status_q;
    if (wr && paddr == int_clear_ofs) begin
      status_d = status_q & ~pwdata[1:0];
    end
    // a match in the clearing cycle is kept
    if (hit_duty) begin
      status_d[duty_irq_bit] = 1'b1;
    end
    if (hit_period) begin
      status_d[period_irq_bit] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 2'h0;
    end else begin
      status_q <= status_d;
    end
  end
  assign irq = |live;
  always_comb begin
    irq_level = 3'h0;
    if (live[duty_irq_bit]) begin
      irq_level = lvl_duty;
    end
    if (live[period_irq_bit] && lvl_period > irq_level) begin
      irq_level = lvl_period;
    end
  end

  // ---------------------------------------------------------------
  // read path, sampled in the setup cycle
  // ---------------------------------------------------------------
  logic [31:0] prdata_q;
  logic err_q;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == run_control_ofs) begin
      rd_mux = {24'h0, dbe_q, 4'h0, prun_q, 1'b0, run_q};
    end else if (paddr == mode_ofs) begin
      rd_mux = {28'h0, 1'b0, mode_q[2:0]};
    end else if (paddr == ff_control_ofs) begin
      rd_mux = {27'h0, ff_q, ffc_q[3:2], 2'h3};
    end else if (paddr == duty_ofs) begin
      rd_mux = {16'h0, duty_q};
    end else if (paddr == period_ofs) begin
      rd_mux = {16'h0, period_q};
    end else if (paddr == capture_ofs) begin
      rd_mux = {16'h0, capture_q};
    end else if (paddr == counter_ofs) begin
      rd_mux = {16'h0, cnt_q};
    end else if (paddr == int_status_ofs) begin
      rd_mux = {30'h0, status_q};
    end else if (paddr == int_clear_ofs) begin
      rd_mux = 32'h0000_0000;
    end else if (paddr == int_enable_ofs) begin
      rd_mux = {24'h0, int_en_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q <= rd_err;
    end
  end
  assign prdata = prdata_q;
  assign pslverr = penable & err_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  period_irq_set_a: assert property (hit_period |=> status_q[period_irq_bit])
    else $error("period match did not set its status bit");
  event_count_a: assert property (run_q && clk_src == src_external && prun_q && ext_rise
      && !wrap |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("pin edge did not advance the counter");
  flop_toggle_a: assert property (hit_duty && ffc_q[ff_duty_trig_pos] && ff_wr == no_ff_write
      |=> ff_q != $past(ff_q))
    else $error("duty match did not invert the output flop");
  duty_reload_a: assert property (dbe_q && hit_period |=> duty_q == $past(duty_buf_q))
    else $error("buffered duty not loaded at period match");
  src_select_a: assert property (clk_src != src_external && !(&(presc_q | ~presc_mask))
      |-> !tick)
    else $error("counter ticked off the selected prescaler tap");
  irq_level_a: assert property (status_q[period_irq_bit] && int_en_q[period_enable_pos]
      |-> irq && irq_level >= lvl_period)
    else $error("enabled pending interrupt not signalled at its level");
  stop_clear_a: assert property (!run_q [*2] |-> cnt_q == 16'h0000)
    else $error("stopped counter not held at zero");
  duty_match_a: assert property (hit_duty |=> status_q[duty_irq_bit])
    else $error("duty match did not set its status bit");
  flop_set_a: assert property (wr && paddr == ff_control_ofs
      && pwdata[1:0] == ff_code_set |=> ff_q)
    else $error("set code did not drive the flop high");
  period_wrap_a: assert property (run_q && tick && wrap |=> cnt_q == 16'h0000)
    else $error("counter did not clear after period match");

  period_seen_c: cover property (hit_period ##1 irq);
  event_seen_c: cover property (clk_src == src_external && ext_rise && run_q);
  reload_seen_c: cover property (dbe_q && hit_period);

endmodule : timer16_unit

// *** sim/pin_partner.sv ***
// far-side model: drives the count input pin and times the pulse output pin
`timescale 1ns/100ps
module pin_partner (
  input wire logic clk, // system clock
  output logic event_input_pin, // count pulses towards the timer
  input wire logic pulse_output_pin, // timer output being timed
  output int last_high, // cycles of the last complete high phase
  output int last_low, // cycles of the last complete low phase
  output int edges // output transitions seen
);
  int run_len;
  logic prev;

  initial begin
    event_input_pin = 1'b0;
    prev = 1'b0;
    run_len = 0;
    last_high = 0;
    last_low = 0;
    edges = 0;
  end

  // ---------------------------------------------------------------
  // count pulses
  // ---------------------------------------------------------------
  // phases of 3 cycles, above the 2-cycle minimum of the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      event_input_pin <= 1'b1;
      repeat (3) @(posedge clk);
      event_input_pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : pulses

  // ---------------------------------------------------------------
  // output phase timing
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (pulse_output_pin !== prev) begin
      if (prev) last_high <= run_len;
      else last_low <= run_len;
      edges <= edges + 1;
      run_len <= 1;
    end else run_len <= run_len + 1;
    prev <= pulse_output_pin;
  end
endmodule : pin_partner

// *** sim/testbench.sv ***
// self-checking bench for the 16-bit timer unit over apb
`timescale 1ns/100ps
module testbench import timer16_pkg::*;;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic event_input_pin, pulse_output_pin, irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] irq_level;
  logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic expv [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int last_high, last_low, edges, t1, e0;

  timer16_unit i_timer16_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_pin(event_input_pin), .pulse_output_pin(pulse_output_pin),
    .irq(irq), .irq_level(irq_level));
  pin_partner i_pin_partner (.clk(pclk), .event_input_pin(event_input_pin),
    .pulse_output_pin(pulse_output_pin), .last_high(last_high),
    .last_low(last_low), .edges(edges));

  always #5 pclk = ~pclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // the whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rdc

  task automatic wait_irq;
    do @(posedge pclk); while (irq !== 1'b1);
  endtask : wait_irq

  task automatic wait_pin(input logic v);
    do @(posedge pclk); while (pulse_output_pin !== v);
  endtask : wait_pin

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(duty_ofs, 32'h0000ffff);
    rdc(period_ofs, 32'h0000ffff);
    rdc(mode_ofs, 32'h00000001);
    rdc(int_enable_ofs, 32'h0);
    rdc(int_status_ofs, 32'h0);
    xfer(1'b0, 8'h28, 32'h0);
    chk_bit(rerr, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(ff_control_ofs, {30'h0, codes[i]});
      repeat (2) @(posedge pclk);
      chk_bit(pulse_output_pin, expv[i]);
      xfer(1'b0, ff_control_ofs, 32'h0);
      chk_bit(rdat[ff_state_pos], expv[i]);
    end
    $display("test flop codes done");
    // period value 7 gives 8 ticks per interval
    wr(period_ofs, 32'h7);
    for (int c = 1; c < 4; c++) begin
      wr(run_control_ofs, 32'h04);
      wr(int_clear_ofs, 32'h3);
      wr(mode_ofs, 32'h4 | c);
      wr(int_enable_ofs, 32'hc0);
      wr(run_control_ofs, 32'h05);
      wait_irq();
      t1 = cyc;
      wr(int_clear_ofs, 32'h2);
      wait_irq();
      chk(cyc - t1, 32 << (2 * (c - 1)));
      chk({29'h0, irq_level}, 32'h4);
    end
    wr(int_enable_ofs, 32'h40);
    @(posedge pclk);
    chk_bit(irq, 1'b0);
    rdc(int_status_ofs, 32'h2);
    wr(int_enable_ofs, 32'hc0);
    @(posedge pclk);
    chk_bit(irq, 1'b1);
    wr(run_control_ofs, 32'h04);
    rdc(counter_ofs, 32'h0);
    wr(int_clear_ofs, 32'h3);
    rdc(int_status_ofs, 32'h0);
    chk_bit(irq, 1'b0);
    $display("test interval timer done");
    // pin edges count only while the prescaler run bit is set
    wr(mode_ofs, 32'h0);
    wr(run_control_ofs, 32'h05);
    i_pin_partner.pulses(5);
    repeat (4) @(posedge pclk);
    wr(mode_ofs, 32'h8);
    rdc(capture_ofs, 32'h5);
    wr(run_control_ofs, 32'h01);
    i_pin_partner.pulses(3);
    repeat (4) @(posedge pclk);
    wr(mode_ofs, 32'h8);
    rdc(capture_ofs, 32'h5);
    $display("test event counter done");
    // duty kept below period
    wr(run_control_ofs, 32'h0);
    wr(duty_ofs, 32'h1);
    wr(period_ofs, 32'h5);
    wr(ff_control_ofs, 32'h0e);
    repeat (2) @(posedge pclk);
    chk_bit(pulse_output_pin, 1'b0);
    wr(mode_ofs, 32'h5);
    wr(run_control_ofs, 32'h85);
    e0 = edges;
    while (edges < e0 + 5) @(posedge pclk);
    chk(last_high, 32'd16);
    chk(last_low, 32'd8);
    rdc(int_status_ofs, 32'h3);
    wait_pin(1'b1);
    wr(duty_ofs, 32'h3);
    rdc(duty_ofs, 32'h1);
    wait_pin(1'b0);
    rdc(duty_ofs, 32'h3);
    wait_pin(1'b1);
    wait_pin(1'b0);
    repeat (2) @(posedge pclk);
    chk(last_high, 32'd8);
    $display("test pulse generation done");
    summarize();
  end
endmodule : testbench
